// [asmu_pkg.sv]
package asmu_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int unsigned ASMU_ADDR_W = 12;               // register address width
   localparam int unsigned ASMU_DATA_W = 8;                // register data width

   ////////////////////////////////////////////////////////////////////////////////
   // register addresses
   localparam logic [11:0] ASMU_CTRL_ADDR    = 12'h200;    // link enable, soft reset
   localparam logic [11:0] ASMU_SUMMARY_ADDR = 12'h2C0;    // summary alarm, read only
   localparam logic [11:0] ASMU_FLAGS_ADDR   = 12'h2C1;    // alarm_flags, write one clears
   localparam logic [11:0] ASMU_MASK_ADDR    = 12'h2C2;    // alarm_mask

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned ASMU_FIFO_BIT    = 5;           // lane fifo flag / mask
   localparam int unsigned ASMU_PLL_BIT     = 4;           // serdes pll flag / mask
   localparam int unsigned ASMU_LINK_BIT    = 3;           // link fault flag / mask
   localparam int unsigned ASMU_REALIGN_BIT = 2;           // clock realign flag / mask
   localparam int unsigned ASMU_RSVD_BIT    = 1;           // reserved, resets to one
   localparam int unsigned ASMU_DIV_BIT     = 0;           // divider mismatch flag / mask
   localparam int unsigned ASMU_LINK_EN_BIT = 0;           // control: link enable
   localparam int unsigned ASMU_SOFT_BIT    = 7;           // control: soft reset pulse
   localparam int unsigned ASMU_SUM_BIT     = 0;           // summary alarm position

   ////////////////////////////////////////////////////////////////////////////////
   // reset values and masks
   localparam logic [7:0] ASMU_FLAGS_RST  = 8'h3F;         // every flag set
   localparam logic [7:0] ASMU_MASK_RST   = 8'h3F;         // every alarm masked
   localparam logic [7:0] ASMU_CTRL_RST   = 8'h00;         // link disabled
   localparam logic [7:0] ASMU_ALARM_BITS = 8'h3D;         // flags that feed the summary
   localparam logic [7:0] ASMU_ZERO       = 8'h00;         // idle read data

endpackage

// [asmu_sticky_flags.sv]
`timescale 1ns/1ps
module asmu_sticky_flags
   import asmu_pkg::*;
#(
   parameter int unsigned W       = 8,
   parameter logic [7:0]  RST_VAL = ASMU_FLAGS_RST
)
(
   input  wire logic         i_clk,      // core clock
   input  wire logic         i_rst_n,    // synchronised reset
   input  wire logic [W-1:0] i_set,      // per-bit event
   input  wire logic [W-1:0] i_clr,      // per-bit write-one clear
   input  wire logic         i_reload,   // soft reset: back to reset value
   output logic      [W-1:0] o_flags     // sticky flags
);

   ////////////////////////////////////////////////////////////////////////////////
   // one sticky cell per bit
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         // reload, else set wins over clear
         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
               o_flags[g] <= RST_VAL[g];
            else if (i_reload)
               o_flags[g] <= RST_VAL[g];
            else
               o_flags[g] <= i_set[g] | (o_flags[g] & ~i_clr[g]);
         end
      end
   endgenerate

endmodule

// [asmu_event_detect.sv]
`timescale 1ns/1ps
module asmu_event_detect
   import asmu_pkg::*;
#(
   parameter int unsigned LANES = 8,
   parameter int unsigned DIV_W = 4
)
(
   input  wire logic             i_clk,               // core clock
   input  wire logic             i_rst_n,             // synchronised reset
   input  wire logic             i_link_enable,       // link enable control
   input  wire logic             i_mode_64b66b,       // 1: 64b/66b, 0: 8b/10b
   input  wire logic             i_data_encoding_state_state,    // link fsm in data encoding state
   input  wire logic             i_lane_realign,      // fifo / serializer realignment
   input  wire logic             i_sysref_realign,    // sysref realigned clocks
   input  wire logic [DIV_W-1:0] i_div_ab,            // divider state, channels a/b
   input  wire logic [DIV_W-1:0] i_div_cd,            // divider state, channels c/d
   input  wire logic [LANES-1:0] i_lane_fifo_err,     // per-lane over/underflow
   input  wire logic             i_serdes_pll_locked, // serializer pll lock
   output logic      [7:0]       o_set                // set requests per flag
);

   logic link_en_prev_q;   // link enable one cycle back
   wire  start_up;         // first cycle of enabled link
   wire  fault_8b;         // 8b/10b link fault
   wire  fault_64b;        // 64b/66b link fault

   ////////////////////////////////////////////////////////////////////////////////
   // enable history for start-up detection
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         link_en_prev_q <= 1'b0;
      else
         link_en_prev_q <= i_link_enable;
   end

   assign start_up  = i_link_enable & ~link_en_prev_q;
   assign fault_8b  = i_link_enable & ~i_data_encoding_state_state;
   assign fault_64b = i_link_enable & (start_up | i_lane_realign);

   ////////////////////////////////////////////////////////////////////////////////
   // condition to flag position
   always_comb
   begin
      o_set = ASMU_ZERO;
      o_set[ASMU_LINK_BIT]    = i_mode_64b66b ? fault_64b : fault_8b;
      o_set[ASMU_REALIGN_BIT] = i_sysref_realign;
      o_set[ASMU_DIV_BIT]     = (i_div_ab != i_div_cd);
      o_set[ASMU_FIFO_BIT]    = |i_lane_fifo_err;
      o_set[ASMU_PLL_BIT]     = ~i_serdes_pll_locked;
   end

endmodule

// [asmu_top.sv]
// What this block does
// - 8b/10b: enabled link not encoding sets fault
// - 64b/66b: start-up or realignment sets fault
// - sysref clock realignment sets realign flag
// - a/b versus c/d divider mismatch sets flag
// - flags sticky, write one clears, zero keeps
// - power-on or soft reset sets all flags
// - flags except divider undefined while link disabled
// - mask bit one excludes alarm from summary
// - mask register resets to 0x3F
// - link bit 3, realign 2, divider 0
// - summary high when any unmasked flag other than reserved bit 1 set
// - lane fifo over/underflow sets bit 5
// - serdes pll unlocked sets bit 4
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module asmu_top
   import asmu_pkg::*;
#(
   parameter int unsigned LANES = 8,   // serial lanes
   parameter int unsigned DIV_W = 4    // divider state width
)
(
   input  wire logic             i_sys_clk,           // core clock, 20 mhz
   input  wire logic             i_rst_b,             // async reset, active low
   input  wire logic [11:0]      i_addr,              // register address
   input  wire logic [7:0]       i_wr_data,           // write data
   input  wire logic             i_wr_stb,            // write strobe
   input  wire logic             i_rd_stb,            // read strobe
   input  wire logic             i_mode_64b66b,       // link coding mode
   input  wire logic             i_data_encoding_state_state,    // link fsm encoding data
   input  wire logic             i_lane_realign,      // fifo / serializer realign
   input  wire logic             i_sysref_realign,    // sysref clock realign
   input  wire logic [DIV_W-1:0] i_div_ab,            // divider state a/b
   input  wire logic [DIV_W-1:0] i_div_cd,            // divider state c/d
   input  wire logic [LANES-1:0] i_lane_fifo_err,     // lane fifo faults
   input  wire logic             i_serdes_pll_locked, // serializer pll lock
   output logic      [7:0]       o_rd_data,           // read data, next cycle
   output logic                  o_alarm,             // summary alarm
   output logic                  o_link_enable        // link enable control
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic       rst_meta_q;     // reset synchroniser, first stage
   logic       rst_n;          // reset synchroniser, second stage
   logic [7:0] ctrl_q;         // control register
   logic [7:0] ctrl_d;         // control next value
   logic [7:0] mask_q;         // alarm_mask register
   logic [7:0] mask_d;         // alarm_mask next value
   logic [7:0] flags;          // alarm_flags register
   logic [7:0] set_vec;        // event set requests
   logic [7:0] rd_data_d;      // read data next value
   logic       alarm_d;        // summary next value

   wire        hit_ctrl;       // address decodes
   wire        hit_sum;
   wire        hit_flags;
   wire        hit_mask;
   wire        wr_ctrl;        // write qualifiers
   wire        wr_flags;
   wire        wr_mask;
   wire        soft_rst;       // soft reset pulse
   wire [7:0]  clr_vec;        // write-one clear bits
   wire [7:0]  unmasked;       // flags passing the mask
   wire [7:0]  summary_word;   // summary register image

   ////////////////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // address decode
   assign hit_ctrl  = (i_addr == ASMU_CTRL_ADDR);
   assign hit_sum   = (i_addr == ASMU_SUMMARY_ADDR);
   assign hit_flags = (i_addr == ASMU_FLAGS_ADDR);
   assign hit_mask  = (i_addr == ASMU_MASK_ADDR);

   // qualified writes
   assign wr_ctrl   = i_wr_stb & hit_ctrl;
   assign wr_flags  = i_wr_stb & hit_flags;
   assign wr_mask   = i_wr_stb & hit_mask;

   // soft reset is a write of one, never stored
   assign soft_rst  = wr_ctrl & i_wr_data[ASMU_SOFT_BIT];

   assign clr_vec   = wr_flags ? i_wr_data : ASMU_ZERO;

   ////////////////////////////////////////////////////////////////////////////////
   // control register: link enable kept, soft reset self-clearing
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_ctrl)
      begin
         ctrl_d                   = ASMU_CTRL_RST;
         ctrl_d[ASMU_LINK_EN_BIT] = i_wr_data[ASMU_LINK_EN_BIT];
      end
   end

   // control flop
   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_q <= ASMU_CTRL_RST;
      else
         ctrl_q <= ctrl_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mask register: stored whole, reserved bits as software writes them
   always_comb
   begin
      mask_d = mask_q;
      if (wr_mask)
         mask_d = i_wr_data;
   end

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         mask_q <= ASMU_MASK_RST;
      else
         mask_q <= mask_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // event conditions from the link and clocking logic
   // link enable gates link fault
   asmu_event_detect #(
      .LANES (LANES),
      .DIV_W (DIV_W)
   ) u_events (
      .i_clk               (i_sys_clk),
      .i_rst_n             (rst_n),
      .i_link_enable       (ctrl_q[ASMU_LINK_EN_BIT]),
      .i_mode_64b66b       (i_mode_64b66b),
      .i_data_encoding_state_state    (i_data_encoding_state_state),
      .i_lane_realign      (i_lane_realign),
      .i_sysref_realign    (i_sysref_realign),
      .i_div_ab            (i_div_ab),
      .i_div_cd            (i_div_cd),
      .i_lane_fifo_err     (i_lane_fifo_err),
      .i_serdes_pll_locked (i_serdes_pll_locked),
      .o_set               (set_vec)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // sticky alarm flags
   // reset and soft reset reload
   asmu_sticky_flags #(
      .W       (8),
      .RST_VAL (ASMU_FLAGS_RST)
   ) u_flags (
      .i_clk    (i_sys_clk),
      .i_rst_n  (rst_n),
      .i_set    (set_vec),
      .i_clr    (clr_vec),
      .i_reload (soft_rst),
      .o_flags  (flags)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // summary alarm
   // mask one drops alarm
   assign unmasked     = flags & ~mask_q & ASMU_ALARM_BITS;
   assign summary_word = {7'h00, o_alarm};

   always_comb
   begin
      alarm_d = |unmasked;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux, data valid only in the cycle after the strobe
   always_comb
   begin
      rd_data_d = ASMU_ZERO;
      if (i_rd_stb)
      begin
         if (hit_ctrl)
            rd_data_d = ctrl_q;
         else if (hit_sum)
            rd_data_d = summary_word;
         else if (hit_flags)
            rd_data_d = flags;
         else if (hit_mask)
            rd_data_d = mask_q;
      end
   end

   // output flops
   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_rd_data     <= ASMU_ZERO;
         o_alarm       <= 1'b0;
         o_link_enable <= 1'b0;
      end
      else
      begin
         o_rd_data     <= rd_data_d;
         o_alarm       <= alarm_d;
         o_link_enable <= ctrl_d[ASMU_LINK_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   property p_link_8b;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (ctrl_q[ASMU_LINK_EN_BIT] && !i_mode_64b66b && !i_data_encoding_state_state)
      |=> flags[ASMU_LINK_BIT];
   endproperty
   a_link_8b: assert property (p_link_8b)
      else $error("link fault flag not set in 8b/10b mode");

   property p_link_64b;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (i_mode_64b66b && $rose(ctrl_q[ASMU_LINK_EN_BIT]))
      |=> flags[ASMU_LINK_BIT];
   endproperty
   a_link_64b: assert property (p_link_64b)
      else $error("link fault flag not set at 64b/66b start-up");

   property p_realign;
      @(posedge i_sys_clk) disable iff (!rst_n)
      i_sysref_realign |=> flags[ASMU_REALIGN_BIT];
   endproperty
   a_realign: assert property (p_realign)
      else $error("realign flag not set after sysref event");

   property p_div;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (i_div_ab != i_div_cd) |=> flags[ASMU_DIV_BIT];
   endproperty
   a_div: assert property (p_div)
      else $error("divider mismatch flag not set");

   property p_keep_on_zero;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (wr_flags && i_wr_data == ASMU_ZERO && !soft_rst)
      |=> ((flags & $past(flags)) == $past(flags));
   endproperty
   a_keep_on_zero: assert property (p_keep_on_zero)
      else $error("flag lost on write of zero");

   property p_clear;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (wr_flags && !soft_rst && set_vec == ASMU_ZERO)
      |=> ((flags & $past(i_wr_data)) == ASMU_ZERO);
   endproperty
   a_clear: assert property (p_clear)
      else $error("written one did not clear flag");

   property p_soft;
      @(posedge i_sys_clk) disable iff (!rst_n)
      soft_rst |=> (flags == ASMU_FLAGS_RST);
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft reset did not set all flags");

   property p_mask_rst;
      @(posedge i_sys_clk) disable iff (!rst_n)
      !$past(rst_n) |-> (mask_q == ASMU_MASK_RST && flags == ASMU_FLAGS_RST);
   endproperty
   a_mask_rst: assert property (p_mask_rst)
      else $error("mask or flags wrong after reset");

   property p_masked_quiet;
      @(posedge i_sys_clk) disable iff (!rst_n)
      ((mask_q & ASMU_ALARM_BITS) == ASMU_ALARM_BITS) [*2] |-> !o_alarm;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet)
      else $error("summary alarm raised while fully masked");

   property p_summary;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (flags[ASMU_LINK_BIT] && !mask_q[ASMU_LINK_BIT]) |=> o_alarm;
   endproperty
   a_summary: assert property (p_summary)
      else $error("summary alarm missing for unmasked flag");

   property p_fifo;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (|i_lane_fifo_err) |=> flags[ASMU_FIFO_BIT];
   endproperty
   a_fifo: assert property (p_fifo)
      else $error("lane fifo flag not set");

   property p_pll;
      @(posedge i_sys_clk) disable iff (!rst_n)
      !i_serdes_pll_locked |=> flags[ASMU_PLL_BIT];
   endproperty
   a_pll: assert property (p_pll)
      else $error("serdes pll flag not set");

   property p_set_wins;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (wr_flags && ((i_wr_data & set_vec) != ASMU_ZERO))
      |=> ((flags & $past(set_vec)) == $past(set_vec));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a simultaneous event");

   property p_link_realign;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (ctrl_q[ASMU_LINK_EN_BIT] && i_mode_64b66b && i_lane_realign)
      |=> flags[ASMU_LINK_BIT];
   endproperty
   a_link_realign: assert property (p_link_realign)
      else $error("link fault flag not set on lane realignment");

   property p_summary_off;
      @(posedge i_sys_clk) disable iff (!rst_n)
      ((flags & ~mask_q & ASMU_ALARM_BITS) == ASMU_ZERO) |=> !o_alarm;
   endproperty
   a_summary_off: assert property (p_summary_off)
      else $error("summary alarm raised with no unmasked flag");

   property p_read_slot;
      @(posedge i_sys_clk) disable iff (!rst_n)
      (i_rd_stb && hit_mask) |=> (o_rd_data == $past(mask_q));
   endproperty
   a_read_slot: assert property (p_read_slot)
      else $error("read data not in the cycle after strobe");

endmodule

// [asmu_top_test.sv]
`timescale 1ns/1ps
module asmu_top_test;
   import asmu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // design ports
   logic             i_sys_clk;           // core clock
   logic             i_rst_b;             // reset, active low
   logic [11:0]      i_addr;              // register address
   logic [7:0]       i_wr_data;           // write data
   logic             i_wr_stb;            // write strobe
   logic             i_rd_stb;            // read strobe
   logic             i_mode_64b66b;       // link coding mode
   logic             i_data_encoding_state_state;    // link fsm encoding
   logic             i_lane_realign;      // lane realignment pulse
   logic             i_sysref_realign;    // sysref realignment pulse
   logic [3:0]       i_div_ab;            // divider state a/b
   logic [3:0]       i_div_cd;            // divider state c/d
   logic [7:0]       i_lane_fifo_err;     // lane fifo faults
   logic             i_serdes_pll_locked; // pll lock level
   logic [7:0]       o_rd_data;           // read data
   logic             o_alarm;             // summary alarm
   logic             o_link_enable;       // link enable control
   int               error_cnt;           // mismatches seen
   int               comparisons;         // checks made
   logic [7:0]       d;                   // read scratch
   logic [7:0]       e;                   // event set scratch
   logic [7:0]       m;                   // mask scratch
   int               ev_bits [5] = '{0, 2, 3, 4, 5}; // flags with a hardware source

   asmu_top dut_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
      .i_mode_64b66b(i_mode_64b66b), .i_data_encoding_state_state(i_data_encoding_state_state),
      .i_lane_realign(i_lane_realign), .i_sysref_realign(i_sysref_realign),
      .i_div_ab(i_div_ab), .i_div_cd(i_div_cd), .i_lane_fifo_err(i_lane_fifo_err),
      .i_serdes_pll_locked(i_serdes_pll_locked), .o_rd_data(o_rd_data),
      .o_alarm(o_alarm), .o_link_enable(o_link_enable));

   ////////////////////////////////////////////////////////////////////////////////
   // 20 mhz clock
   initial
   begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   // expected summary from flags and mask
   function automatic logic exp_alarm(input logic [7:0] f, input logic [7:0] mk);
      return |(f & ~mk & 8'h3D);
   endfunction

   // compare and count
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask

   // single-cycle write
   task automatic reg_write(input logic [11:0] a, input logic [7:0] wd);
      @(posedge i_sys_clk);
      i_wr_stb  <= 1'b1;
      i_addr    <= a;
      i_wr_data <= wd;
      @(posedge i_sys_clk);
      i_wr_stb  <= 1'b0;
   endtask

   // single-cycle read, data taken in the following cycle
   task automatic reg_read(input logic [11:0] a, output logic [7:0] rd);
      @(posedge i_sys_clk);
      i_rd_stb <= 1'b1;
      i_addr   <= a;
      @(posedge i_sys_clk);
      i_rd_stb <= 1'b0;
      #1 rd = o_rd_data;
   endtask

   // let a few edges pass, then sit off the edge
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask

   // drive the alarm sources for the flag bits in ev
   task automatic set_events(input logic [7:0] ev);
      i_div_cd            <= ev[0] ? ~i_div_ab : i_div_ab;
      i_sysref_realign    <= ev[2];
      i_data_encoding_state_state    <= ~ev[3];
      i_serdes_pll_locked <= ~ev[4];
      i_lane_fifo_err     <= ev[5] ? 8'(($urandom % 255) + 1) : 8'h00;
   endtask

   // one cycle of events, then quiet
   task automatic pulse(input logic [7:0] ev);
      @(posedge i_sys_clk);
      set_events(ev);
      @(posedge i_sys_clk);
      set_events(8'h00);
   endtask

   // verdict and end of run
   task automatic complete_run();
      if (error_cnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      error_cnt++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      error_cnt = 0;
      comparisons = 0;
      i_rst_b = 1'b0;
      i_addr = 12'h000;
      i_wr_data = 8'h00;
      i_wr_stb = 1'b0;
      i_rd_stb = 1'b0;
      i_mode_64b66b = 1'b0;
      i_data_encoding_state_state = 1'b1;
      i_lane_realign = 1'b0;
      i_sysref_realign = 1'b0;
      i_div_ab = 4'h5;
      i_div_cd = 4'h5;
      i_lane_fifo_err = 8'h00;
      i_serdes_pll_locked = 1'b1;
      void'($urandom(17420));
      repeat (4) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      wait_cyc(3);
      reg_read(ASMU_FLAGS_ADDR, d); check(d, 8'h3F);
      reg_read(ASMU_MASK_ADDR, d);  check(d, 8'h3F);
      check({7'h0, o_alarm}, 8'h00);
      // enable link and clear stale flags
      reg_write(ASMU_CTRL_ADDR, 8'h01);
      wait_cyc(1);
      check({7'h0, o_link_enable}, 8'h01);
      reg_write(ASMU_FLAGS_ADDR, 8'h3F);
      reg_read(ASMU_FLAGS_ADDR, d); check(d, 8'h00);
      // each source sets its own bit
      foreach (ev_bits[i])
      begin
         e = 8'h01 << ev_bits[i];
         pulse(e);
         reg_read(ASMU_FLAGS_ADDR, d); check(d, e);
         reg_write(ASMU_MASK_ADDR, 8'h3F & ~e);
         wait_cyc(2);
         check({7'h0, o_alarm}, 8'h01);
         reg_write(ASMU_MASK_ADDR, 8'h3F);
         wait_cyc(2);
         check({7'h0, o_alarm}, 8'h00);
         reg_write(ASMU_FLAGS_ADDR, 8'h3F & ~e);
         reg_read(ASMU_FLAGS_ADDR, d); check(d, e);
         reg_write(ASMU_FLAGS_ADDR, e);
         reg_read(ASMU_FLAGS_ADDR, d); check(d, 8'h00);
      end
      // clear while the pll is still unlocked
      @(posedge i_sys_clk);
      set_events(8'h10);
      reg_write(ASMU_FLAGS_ADDR, 8'h10);
      set_events(8'h00);
      reg_read(ASMU_FLAGS_ADDR, d); check(d, 8'h10);
      reg_write(ASMU_FLAGS_ADDR, 8'h10);
      reg_read(ASMU_FLAGS_ADDR, d); check(d, 8'h00);
      reg_write(ASMU_CTRL_ADDR, 8'h00);
      i_mode_64b66b <= 1'b1;
      reg_write(ASMU_CTRL_ADDR, 8'h01);
      reg_read(ASMU_FLAGS_ADDR, d); check(d & 8'h08, 8'h08);
      i_data_encoding_state_state <= 1'b0;
      reg_write(ASMU_FLAGS_ADDR, 8'h3F);
      reg_read(ASMU_FLAGS_ADDR, d); check(d, 8'h00);
      @(posedge i_sys_clk);
      i_lane_realign <= 1'b1;
      @(posedge i_sys_clk);
      i_lane_realign <= 1'b0;
      i_data_encoding_state_state <= 1'b1;
      reg_read(ASMU_FLAGS_ADDR, d); check(d, 8'h08);
      i_mode_64b66b <= 1'b0;
      // random masks and event mixes against the summary
      repeat (16)
      begin
         m = 8'(($urandom & 8'h3D) | 8'h02);
         e = 8'($urandom & 8'h3D);
         reg_write(ASMU_FLAGS_ADDR, 8'h3F);
         reg_write(ASMU_MASK_ADDR, m);
         pulse(e);
         reg_read(ASMU_FLAGS_ADDR, d); check(d, e);
         reg_read(ASMU_MASK_ADDR, d); check(d, m);
         check({7'h0, o_alarm}, {7'h0, exp_alarm(e, m)});
         reg_read(ASMU_SUMMARY_ADDR, d); check(d, {7'h0, exp_alarm(e, m)});
      end
      // soft reset reloads flags, keeps mask; back-to-back strobes
      @(posedge i_sys_clk);
      i_wr_stb  <= 1'b1;
      i_addr    <= ASMU_MASK_ADDR;
      i_wr_data <= 8'h27;
      @(posedge i_sys_clk);
      i_wr_stb  <= 1'b0;
      i_rd_stb  <= 1'b1;
      @(posedge i_sys_clk);
      i_rd_stb  <= 1'b0;
      #1 check(o_rd_data, 8'h27);
      reg_write(ASMU_CTRL_ADDR, 8'h81);
      reg_read(ASMU_FLAGS_ADDR, d); check(d, 8'h3F);
      reg_read(ASMU_MASK_ADDR, d);  check(d, 8'h27);
      reg_read(ASMU_CTRL_ADDR, d);  check(d, 8'h01);
      check({7'h0, o_alarm}, {7'h0, exp_alarm(8'h3F, 8'h27)});
      // summary is read only, unmapped places read zero
      reg_write(ASMU_SUMMARY_ADDR, 8'h00);
      reg_read(ASMU_SUMMARY_ADDR, d); check(d, 8'h01);
      reg_write(12'h2C3, 8'hFF);
      reg_read(12'h2C3, d); check(d, 8'h00);
      reg_read(ASMU_MASK_ADDR, d); check(d, 8'h27);
      wait_cyc(1);
      check(o_rd_data, 8'h00);
      complete_run();
   end

endmodule
